// ---- design/oflr_pkg.sv ----
/*
 * Shared constants and types for the output fault limit and response block.
 * Assumes a 50 MHz core clock and two output pages.
 */
package oflr_pkg;
    // ************************************************************
    // Sizes, command codes and reset values
    // ************************************************************
    localparam int NP = 2;
    localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CODE_UV_ACTION = 8'h45;
    localparam logic [7:0] CODE_OC_LIMIT = 8'h46;
    localparam logic [7:0] CODE_UC_LIMIT = 8'h4b;
    localparam logic [7:0] UV_ACTION_RST = 8'h80;
    localparam logic [15:0] OC_LIMIT_RST = 16'hda80;
    localparam logic [15:0] UC_LIMIT_RST = 16'hdd80;
    // ************************************************************
    // Field layouts
    // ************************************************************
    localparam int BEHAV_HI = 7;
    localparam int BEHAV_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam logic [1:0] BEHAV_RETRY = 2'h2;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MANT_HI = 10;
    localparam logic signed [5:0] FRAC_BITS = 6'sh08;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int RETRY_UNIT_MS = 70;
    localparam int CLK_KHZ = 50_000;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * CLK_KHZ;
    localparam int TMR_W = 22;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_ON = 4'h2,
        ST_LATCH = 4'h4,
        ST_RETRY = 4'h8
    } oflr_st_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic page;
        logic [7:0] code;
        logic [15:0] wdata;
    } oflr_cmd_t;
    typedef struct packed {
        logic valid;
        logic page;
        logic blanked;
        logic signed [23:0] current;
    } oflr_sample_t;
    typedef struct packed {
        logic [7:0] uv_action;
        logic [15:0] oc_limit;
        logic [15:0] uc_limit;
        oflr_st_t st;
        logic [TMR_W-1:0] timer;
        logic [CNT_W-1:0] oc_cnt;
        logic [CNT_W-1:0] uc_cnt;
        logic uv_flag;
        logic oc_flag;
        logic uc_flag;
        logic out_en;
        logic oc_trip;
        logic uc_trip;
    } oflr_page_t;
    typedef struct packed {
        oflr_page_t [NP-1:0] page;
        logic [NP-1:0] reg_s1;
        logic [NP-1:0] reg_s2;
        logic [NP-1:0] uv_s1;
        logic [NP-1:0] uv_s2;
        logic [NP-1:0] en_s1;
        logic [NP-1:0] en_s2;
        logic [15:0] rdata;
        logic rvalid;
        logic alert_n;
    } oflr_state_t;
endpackage : oflr_pkg

// ---- design/oflr_top.sv ----
/*
 * Output fault limits and undervoltage response for each output page.
 * Assumes commands arrive already decoded from the serial bus on REF_CLK,
 * current samples come from logic on REF_CLK, and pins are asynchronous.
 */
`timescale 1ns/1ps
module oflr_top #(
    parameter int unsigned RETRY_CYCLES = oflr_pkg::RETRY_UNIT_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire oflr_pkg::oflr_cmd_t CMD,
    input wire oflr_pkg::oflr_sample_t SAMPLE,
    input wire logic [oflr_pkg::CNT_W-1:0] SAMPLE_COUNT,
    input wire logic [oflr_pkg::NP-1:0] OUTPUT_IN_REGULATION,
    input wire logic [oflr_pkg::NP-1:0] UV_DETECT,
    input wire logic [oflr_pkg::NP-1:0] ENABLE_PIN,
    input wire logic [oflr_pkg::NP-1:0] OPERATION_ON,
    input wire logic [oflr_pkg::NP-1:0] OTHER_FAULT_OFF,
    input wire logic [oflr_pkg::NP-1:0] AVG_OC_TRIP,
    input wire logic [oflr_pkg::NP-1:0] AVG_UC_TRIP,
    output logic [15:0] RDATA,
    output logic RVALID,
    output logic ALERT_OUT_N,
    output logic [oflr_pkg::NP-1:0] OUTPUT_EN,
    output logic [oflr_pkg::NP-1:0] UV_FAULT_FLAG,
    output logic [oflr_pkg::NP-1:0] OC_FAULT_FLAG,
    output logic [oflr_pkg::NP-1:0] UC_FAULT_FLAG,
    output logic [oflr_pkg::NP-1:0] OC_TRIP,
    output logic [oflr_pkg::NP-1:0] UC_TRIP
);
    // ************************************************************
    // Helpers
    // ************************************************************
    localparam logic [oflr_pkg::TMR_W-1:0] RETRY_LOAD = oflr_pkg::TMR_W'(RETRY_CYCLES - 1);

    function automatic logic cmd_hit(oflr_pkg::oflr_cmd_t c, logic [7:0] code, int p);
        cmd_hit = c.valid && c.write && c.code == code && c.page == 1'(p);
    endfunction : cmd_hit

    // Converts an exponent-mantissa value to signed fixed point.
    function automatic logic signed [47:0] lin_to_fix(logic [15:0] v);
        logic signed [5:0] sh;
        logic signed [47:0] m;
        sh = 6'(signed'(v[oflr_pkg::EXP_HI:oflr_pkg::EXP_LO])) + oflr_pkg::FRAC_BITS;
        m = 48'(signed'(v[oflr_pkg::MANT_HI:0]));
        if (sh >= 0) begin
            lin_to_fix = m <<< sh;
        end else begin
            lin_to_fix = m >>> (-sh);
        end
    endfunction : lin_to_fix

    oflr_pkg::oflr_state_t r_reg;
    oflr_pkg::oflr_state_t r_next;
    logic clear_all;
    logic [oflr_pkg::NP-1:0] uv_evt;
    logic [oflr_pkg::NP-1:0] run;
    logic [oflr_pkg::NP-1:0] samp_ok;
    logic [oflr_pkg::NP-1:0] oc_viol;
    logic [oflr_pkg::NP-1:0] uc_viol;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [oflr_pkg::CNT_W-1:0] need;
        logic [1:0] behav;
        logic [2:0] retry;
        logic signed [47:0] samp;
        logic any_flag;
        r_next = r_reg;
        need = (SAMPLE_COUNT == '0) ? oflr_pkg::CNT_ONE : SAMPLE_COUNT;
        samp = 48'(SAMPLE.current);
        any_flag = 1'b0;
        behav = '0;
        retry = '0;
        r_next.rvalid = 1'b0;
        r_next.reg_s1 = OUTPUT_IN_REGULATION;
        r_next.reg_s2 = r_reg.reg_s1;
        r_next.uv_s1 = UV_DETECT;
        r_next.uv_s2 = r_reg.uv_s1;
        r_next.en_s1 = ENABLE_PIN;
        r_next.en_s2 = r_reg.en_s1;
        clear_all = CMD.valid && CMD.write && CMD.code == oflr_pkg::CODE_CLEAR_FAULTS;
        for (int p = 0; p < oflr_pkg::NP; p++) begin
            if (cmd_hit(CMD, oflr_pkg::CODE_UV_ACTION, p)) begin
                r_next.page[p].uv_action = CMD.wdata[7:0];
            end
            if (cmd_hit(CMD, oflr_pkg::CODE_OC_LIMIT, p)) begin
                r_next.page[p].oc_limit = CMD.wdata;
            end
            if (cmd_hit(CMD, oflr_pkg::CODE_UC_LIMIT, p)) begin
                r_next.page[p].uc_limit = CMD.wdata;
            end
            run[p] = r_reg.en_s2[p] && OPERATION_ON[p] && !OTHER_FAULT_OFF[p];
            uv_evt[p] = r_reg.uv_s2[p] && r_reg.reg_s2[p] && r_reg.page[p].st == oflr_pkg::ST_ON;
            behav = r_reg.page[p].uv_action[oflr_pkg::BEHAV_HI:oflr_pkg::BEHAV_LO];
            retry = r_reg.page[p].uv_action[oflr_pkg::RETRY_HI:oflr_pkg::RETRY_LO];
            unique case (r_reg.page[p].st)
                oflr_pkg::ST_OFF: begin
                    if (run[p]) begin
                        r_next.page[p].st = oflr_pkg::ST_ON;
                    end
                end
                oflr_pkg::ST_ON: begin
                    if (!run[p]) begin
                        r_next.page[p].st = oflr_pkg::ST_OFF;
                    end else if (uv_evt[p]) begin
                        if (behav == oflr_pkg::BEHAV_RETRY && retry == oflr_pkg::RETRY_FOREVER) begin
                            r_next.page[p].st = oflr_pkg::ST_RETRY;
                            r_next.page[p].timer = RETRY_LOAD;
                        end else begin
                            r_next.page[p].st = oflr_pkg::ST_LATCH;
                        end
                    end
                end
                oflr_pkg::ST_LATCH: begin
                    if (clear_all) begin
                        r_next.page[p].st = oflr_pkg::ST_OFF;
                    end
                end
                oflr_pkg::ST_RETRY: begin
                    if (!run[p]) begin
                        r_next.page[p].st = oflr_pkg::ST_OFF;
                    end else if (r_reg.page[p].timer == '0) begin
                        r_next.page[p].st = oflr_pkg::ST_ON;
                    end else begin
                        r_next.page[p].timer = r_reg.page[p].timer - 1'b1;
                    end
                end
                default: begin
                    r_next.page[p].st = oflr_pkg::ST_OFF;
                end
            endcase
            r_next.page[p].out_en = r_next.page[p].st == oflr_pkg::ST_ON;
            // Blanked samples only; any in-range sample restarts the run count.
            samp_ok[p] = SAMPLE.valid && SAMPLE.blanked && SAMPLE.page == 1'(p);
            oc_viol[p] = samp > lin_to_fix(r_reg.page[p].oc_limit);
            uc_viol[p] = samp < lin_to_fix(r_reg.page[p].uc_limit);
            r_next.page[p].oc_trip = AVG_OC_TRIP[p];
            r_next.page[p].uc_trip = AVG_UC_TRIP[p];
            if (samp_ok[p]) begin
                if (!oc_viol[p]) begin
                    r_next.page[p].oc_cnt = '0;
                end else if (r_reg.page[p].oc_cnt < need) begin
                    r_next.page[p].oc_cnt = r_reg.page[p].oc_cnt + 1'b1;
                    if (r_reg.page[p].oc_cnt + 1'b1 == need) begin
                        r_next.page[p].oc_trip = 1'b1;
                    end
                end
                if (!uc_viol[p]) begin
                    r_next.page[p].uc_cnt = '0;
                end else if (r_reg.page[p].uc_cnt < need) begin
                    r_next.page[p].uc_cnt = r_reg.page[p].uc_cnt + 1'b1;
                    if (r_reg.page[p].uc_cnt + 1'b1 == need) begin
                        r_next.page[p].uc_trip = 1'b1;
                    end
                end
            end
            // A fault arriving with a clear still sets its flag.
            r_next.page[p].uv_flag = (r_reg.page[p].uv_flag && !clear_all) || uv_evt[p];
            r_next.page[p].oc_flag = (r_reg.page[p].oc_flag && !clear_all)
                || r_next.page[p].oc_trip;
            r_next.page[p].uc_flag = (r_reg.page[p].uc_flag && !clear_all)
                || r_next.page[p].uc_trip;
            any_flag = any_flag || r_next.page[p].uv_flag || r_next.page[p].oc_flag
                || r_next.page[p].uc_flag;
        end
        r_next.alert_n = !any_flag;
        if (CMD.valid && !CMD.write) begin
            r_next.rvalid = 1'b1;
            case (CMD.code)
                oflr_pkg::CODE_UV_ACTION: r_next.rdata = {8'h00, r_reg.page[CMD.page].uv_action};
                oflr_pkg::CODE_OC_LIMIT: r_next.rdata = r_reg.page[CMD.page].oc_limit;
                oflr_pkg::CODE_UC_LIMIT: r_next.rdata = r_reg.page[CMD.page].uc_limit;
                default: r_next.rdata = 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            r_reg <= '0;
            r_reg.alert_n <= 1'b1;
            for (int p = 0; p < oflr_pkg::NP; p++) begin
                r_reg.page[p].uv_action <= oflr_pkg::UV_ACTION_RST;
                r_reg.page[p].oc_limit <= oflr_pkg::OC_LIMIT_RST;
                r_reg.page[p].uc_limit <= oflr_pkg::UC_LIMIT_RST;
                r_reg.page[p].st <= oflr_pkg::ST_OFF;
            end
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign RDATA = r_reg.rdata;
    assign RVALID = r_reg.rvalid;
    assign ALERT_OUT_N = r_reg.alert_n;
    for (genvar g = 0; g < oflr_pkg::NP; g++) begin : g_out
        assign OUTPUT_EN[g] = r_reg.page[g].out_en;
        assign UV_FAULT_FLAG[g] = r_reg.page[g].uv_flag;
        assign OC_FAULT_FLAG[g] = r_reg.page[g].oc_flag;
        assign UC_FAULT_FLAG[g] = r_reg.page[g].uc_flag;
        assign OC_TRIP[g] = r_reg.page[g].oc_trip;
        assign UC_TRIP[g] = r_reg.page[g].uc_trip;
    end

    // ************************************************************
    // Checks on page 0, plus the page 1 uv_action reset value
    // ************************************************************
    property p_uv_masked;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (r_reg.page[0].st == oflr_pkg::ST_ON && !r_reg.reg_s2[0])
        |=> r_reg.page[0].st inside {oflr_pkg::ST_ON, oflr_pkg::ST_OFF};
    endproperty
    a_uv_masked: assert property (p_uv_masked) else $error("uv acted on out of regulation");
    property p_reset_vals;
        @(posedge REF_CLK) $past(SYS_RST) && !SYS_RST
        |-> r_reg.page[1].uv_action == oflr_pkg::UV_ACTION_RST
        && r_reg.page[0].oc_limit == oflr_pkg::OC_LIMIT_RST
        && r_reg.page[0].uc_limit == oflr_pkg::UC_LIMIT_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
    property p_latch_path;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (uv_evt[0] && run[0]
        && r_reg.page[0].uv_action[oflr_pkg::BEHAV_HI:oflr_pkg::RETRY_LO]
        != {oflr_pkg::BEHAV_RETRY, oflr_pkg::RETRY_FOREVER})
        |=> r_reg.page[0].st == oflr_pkg::ST_LATCH && !OUTPUT_EN[0];
    endproperty
    a_latch_path: assert property (p_latch_path) else $error("uv did not latch off");
    property p_latch_hold;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (r_reg.page[0].st == oflr_pkg::ST_LATCH && !clear_all) |=> $stable(r_reg.page[0].st);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched page left early");
    property p_retry_count;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (r_reg.page[0].st == oflr_pkg::ST_RETRY && run[0] && r_reg.page[0].timer != '0)
        |=> r_reg.page[0].st == oflr_pkg::ST_RETRY
        && r_reg.page[0].timer == $past(r_reg.page[0].timer) - 1'b1;
    endproperty
    a_retry_count: assert property (p_retry_count) else $error("retry timer slip");
    property p_restart;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (r_reg.page[0].st == oflr_pkg::ST_RETRY && run[0] && r_reg.page[0].timer == '0)
        |=> OUTPUT_EN[0] ##1 (OUTPUT_EN[0] || !$past(run[0]) || $past(uv_evt[0]));
    endproperty
    a_restart: assert property (p_restart) else $error("retry did not restart");
    property p_uv_alert;
        @(posedge REF_CLK) disable iff (SYS_RST)
        uv_evt[0] |=> UV_FAULT_FLAG[0] && !ALERT_OUT_N ##1 (UV_FAULT_FLAG[0] || $past(clear_all));
    endproperty
    a_uv_alert: assert property (p_uv_alert) else $error("uv flag or alert missing");
    property p_blank_ignored;
        @(posedge REF_CLK) disable iff (SYS_RST)
        !samp_ok[0] |=> $stable(r_reg.page[0].oc_cnt) && $stable(r_reg.page[0].uc_cnt);
    endproperty
    a_blank_ignored: assert property (p_blank_ignored) else $error("unblanked sample counted");
    property p_cnt_clear;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (samp_ok[0] && !oc_viol[0]) |=> r_reg.page[0].oc_cnt == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");
    property p_shared_flags;
        @(posedge REF_CLK) disable iff (SYS_RST)
        (OC_TRIP[0] |-> OC_FAULT_FLAG[0]) and (UC_TRIP[0] |-> UC_FAULT_FLAG[0]);
    endproperty
    a_shared_flags: assert property (p_shared_flags) else $error("trip without flag");
endmodule : oflr_top

// ---- dv/oflr_stage.sv ----
/*
 * Behavioural output power stage for the fault limit bench.
 * Assumes the block's output enable per page and a bench undervoltage request.
 */
`timescale 1ns/1ps
module oflr_stage #(
    parameter int PG_DLY = 4
) (
    input wire logic clk,
    input wire logic [oflr_pkg::NP-1:0] en,
    input wire logic [oflr_pkg::NP-1:0] uv_req,
    output logic [oflr_pkg::NP-1:0] pg,
    output logic [oflr_pkg::NP-1:0] uv
);
    // ************************************************************
    // Output ramp and comparators
    // ************************************************************
    logic [oflr_pkg::NP-1:0] ramp_q [PG_DLY];
    always_ff @(posedge clk) begin
        ramp_q[0] <= en;
        for (int i = 1; i < PG_DLY; i++) begin
            ramp_q[i] <= ramp_q[i-1] & en;
        end
    end
    // Regulation drops at once when disabled, and an unpowered output reads low.
    assign pg = ramp_q[PG_DLY-1] & en;
    assign uv = uv_req | ~pg;
endmodule : oflr_stage

// ---- dv/tb_output_fault_limits_response.sv ----
/*
 * Self-checking bench for the output fault limit and response block.
 * Assumes the power stage model and a shortened retry interval.
 */
`timescale 1ns/1ps
module tb_output_fault_limits_response;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int RC = 20;
    typedef logic [oflr_pkg::NP-1:0] oflr_pv_t;
    logic clk, sys_rst, rvalid, alert_n;
    logic [15:0] rdata;
    logic [3:0] sample_count;
    logic [3:0] trip_seen;
    oflr_pkg::oflr_cmd_t cmd_in;
    oflr_pkg::oflr_sample_t smp_in;
    oflr_pv_t pg, uv, uv_req, en_pin, op_on, oth_off, avg_oc, avg_uc;
    oflr_pv_t en_out, uv_flag, oc_flag, uc_flag, oc_trip, uc_trip;
    int err_count, total_checks, cyc;
    oflr_top #(.RETRY_CYCLES(RC)) dut (.REF_CLK(clk), .SYS_RST(sys_rst), .CMD(cmd_in),
        .SAMPLE(smp_in), .SAMPLE_COUNT(sample_count), .OUTPUT_IN_REGULATION(pg),
        .UV_DETECT(uv), .ENABLE_PIN(en_pin), .OPERATION_ON(op_on),
        .OTHER_FAULT_OFF(oth_off), .AVG_OC_TRIP(avg_oc), .AVG_UC_TRIP(avg_uc),
        .RDATA(rdata), .RVALID(rvalid), .ALERT_OUT_N(alert_n), .OUTPUT_EN(en_out),
        .UV_FAULT_FLAG(uv_flag), .OC_FAULT_FLAG(oc_flag), .UC_FAULT_FLAG(uc_flag),
        .OC_TRIP(oc_trip), .UC_TRIP(uc_trip));
    oflr_stage stage (.clk(clk), .en(en_out), .uv_req(uv_req), .pg(pg), .uv(uv));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic give_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic wr, input logic p, input logic [7:0] c, input logic [15:0] d);
        cmd_in <= '{1'b1, wr, p, c, d};
        @(negedge clk);
        cmd_in.valid <= 1'b0;
        @(negedge clk);
    endtask : cmd
    task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] exp);
        cmd_in <= '{1'b1, 1'b0, p, c, 16'h0000};
        @(negedge clk);
        cmd_in.valid <= 1'b0;
        chk({rvalid, rdata}, {1'b1, exp});
        @(negedge clk);
    endtask : rd
    task automatic smp(input logic p, input logic blk, input logic signed [23:0] amps);
        smp_in <= '{1'b1, p, blk, amps};
        @(negedge clk);
        smp_in.valid <= 1'b0;
        // Trip pulses stand for one cycle only, so they are captured here.
        trip_seen = {oc_trip, uc_trip};
        @(negedge clk);
    endtask : smp
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic reg_case();
        for (int p = 0; p < 2; p++) begin
            rd(p[0], oflr_pkg::CODE_UV_ACTION, 16'h0080);
            rd(p[0], oflr_pkg::CODE_OC_LIMIT, 16'hda80);
            rd(p[0], oflr_pkg::CODE_UC_LIMIT, 16'hdd80);
        end
        rd(1'b0, 8'h47, 16'h0000);
        cmd(1'b1, 1'b1, oflr_pkg::CODE_UV_ACTION, 16'h12a5);
        cmd(1'b1, 1'b1, oflr_pkg::CODE_OC_LIMIT, 16'hd280);
        rd(1'b1, oflr_pkg::CODE_UV_ACTION, 16'h00a5);
        rd(1'b0, oflr_pkg::CODE_UV_ACTION, 16'h0080);
        rd(1'b1, oflr_pkg::CODE_OC_LIMIT, 16'hd280);
        rd(1'b0, oflr_pkg::CODE_OC_LIMIT, 16'hda80);
    endtask : reg_case
    task automatic uv_case(input logic [7:0] code, input int exp_low);
        int n;
        n = 0;
        cmd(1'b1, 1'b0, oflr_pkg::CODE_UV_ACTION, {8'h00, code});
        uv_req[0] <= 1'b1;
        while (en_out[0] === 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        chk({uv_flag, alert_n}, 3'b010);
        n = 0;
        while (en_out[0] === 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(n, exp_low);
        uv_req[0] <= 1'b0;
        repeat (3) @(negedge clk);
        chk(uv_flag[0], 1'b1);
        cmd(1'b1, 1'b0, oflr_pkg::CODE_CLEAR_FAULTS, 16'h0000);
        repeat (12) @(negedge clk);
        chk({uv_flag[0], alert_n, en_out[0]}, 3'b011);
    endtask : uv_case
    task automatic cur_case();
        sample_count <= 4'h2;
        smp(1'b0, 1'b1, 24'sh001500);
        chk(trip_seen, 4'h0);
        smp(1'b0, 1'b0, 24'sh001500);
        chk(trip_seen, 4'h0);
        smp(1'b0, 1'b1, 24'sh001400);
        chk(trip_seen, 4'h0);
        smp(1'b0, 1'b1, 24'sh001500);
        chk(trip_seen, 4'h0);
        smp(1'b0, 1'b1, 24'sh001500);
        chk({trip_seen, oc_flag, alert_n}, 7'b0100010);
        smp(1'b1, 1'b1, -24'sh001500);
        smp(1'b1, 1'b1, -24'sh001500);
        chk({trip_seen, uc_flag}, 6'b001010);
        sample_count <= 4'h0;
        smp(1'b0, 1'b1, 24'sh001000);
        smp(1'b0, 1'b1, 24'sh001500);
        chk(trip_seen, 4'h4);
        avg_oc <= 2'b10;
        avg_uc <= 2'b01;
        @(negedge clk);
        chk({oc_trip, uc_trip}, 4'b1001);
        avg_oc <= 2'b00;
        avg_uc <= 2'b00;
        repeat (2) @(negedge clk);
        chk({oc_flag, uc_flag}, 4'b1111);
        cmd(1'b1, 1'b1, oflr_pkg::CODE_CLEAR_FAULTS, 16'h0000);
        chk({oc_flag, uc_flag, alert_n}, 5'b00001);
    endtask : cur_case
    // ************************************************************
    // Clock, timeout and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc >= 6000) begin
                err_count++;
                give_verdict();
            end
        end
    end
    initial begin
        sys_rst = 1'b1;
        cmd_in = '0;
        smp_in = '0;
        sample_count = 4'h1;
        {uv_req, en_pin, op_on, oth_off, avg_oc, avg_uc} = '0;
        err_count = 0;
        total_checks = 0;
        repeat (5) @(negedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({en_out, uv_flag, alert_n}, 5'b00001);
        reg_case();
        en_pin <= 2'b01;
        op_on <= 2'b01;
        repeat (12) @(negedge clk);
        chk({en_out[0], pg[0], uv_flag[0], alert_n}, 4'b1101);
        uv_case(8'hb8, RC);
        uv_case(8'h98, 40);
        uv_case(8'hf8, 40);
        uv_case(8'h80, 40);
        cur_case();
        give_verdict();
    end
endmodule : tb_output_fault_limits_response
